// [rtl/odt_pkg.sv]
// odt termination control: shared constants and carrier types
package odt_pkg;
  localparam int HIST_W = 40;
  localparam int LAT_W = 6;
  localparam logic [LAT_W-1:0] ODTL_SUB = 6'h02;
  localparam logic [LAT_W-1:0] CWN_BC4 = 6'h04;
  localparam logic [LAT_W-1:0] CWN_BL8 = 6'h06;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] RTT_NOM_OFF = 3'h0;
  localparam logic [1:0] RTT_WR_OFF = 2'h0;
  localparam logic [2:0] RTT_RST = 3'h0;

  // pins sampled on each link clock rising edge
  typedef struct packed {
    logic odt;
    logic wr;
    logic bc4;
  } odt_pin_t;

  // mode register fields that steer termination
  typedef struct packed {
    logic [2:0] rtt_nom;
    logic [1:0] rtt_wr;
    logic [3:0] cwl;
    logic [3:0] al;
  } odt_mode_t;
endpackage

// [rtl/odt_term_ctl.sv]
// odt termination control: pin latencies, dynamic strength switching
// Notes on behaviour
// - termination comes on only once the device stops driving data.
// - dynamic termination is enabled when either write-strength bit is set.
// - nominal strength from mode register 1, write strength from register 2.
// - without a write in progress, nominal strength is applied.
// - termination on and off follow the pin by write latency minus 2.
// - every write command variant triggers strength switching.
// - write strength selected write latency minus 2 after a write.
// - nominal strength returns 4 (chop) or 6 (burst) past turn-off latency.
// - turn-off and strength changes land half a clock after their latency.
// - on timing counts from on latency end, off from off latency end.
// - pin ignored when termination is disabled or in self refresh.
`timescale 1ns/1ns
module odt_term_ctl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_ck,
  input wire odt_pkg::odt_pin_t pins,
  input wire odt_pkg::odt_mode_t mode,
  input wire logic sref,
  input wire logic dq_drive,
  output logic rtt_on_reg,
  output logic rtt_sel_wr_reg,
  output logic [2:0] rtt_value_reg
);
  // three stages on every pin from the link side
  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  logic ck_stable_reg;
  logic ck_rise, ck_fall;
  odt_pkg::odt_pin_t pin_s;
  logic [odt_pkg::HIST_W-1:0] odt_hist_reg, wr_hist_reg, bc4_hist_reg;
  logic [odt_pkg::HIST_W-1:0] odt_hist_next, wr_hist_next, bc4_hist_next;
  logic [odt_pkg::LAT_W-1:0] odtl, cwn4, cwn8;
  logic odt_mode_en, dyn_en, ignore_pin;
  logic on_due, cnw_due, cwn_due;
  logic term_reg, off_pend_reg, cnw_pend_reg, cwn_pend_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= {link_ck, pins};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign pin_s = sync3_reg[2:0];
  // an edge counts once the second and third stages agree
  assign ck_rise = (sync2_reg[3] == sync3_reg[3]) && sync3_reg[3] &&
                   !ck_stable_reg;
  assign ck_fall = (sync2_reg[3] == sync3_reg[3]) && !sync3_reg[3] &&
                   ck_stable_reg;

  always_ff @(posedge clock) begin
    if (!rst_n)
      ck_stable_reg <= 1'b0;
    else if (sync2_reg[3] == sync3_reg[3])
      ck_stable_reg <= sync3_reg[3];
  end

  assign dyn_en = mode.rtt_wr != odt_pkg::RTT_WR_OFF;
  assign odt_mode_en = (mode.rtt_nom != odt_pkg::RTT_NOM_OFF) || dyn_en;
  assign ignore_pin = sref || !odt_mode_en;
  assign odtl = 6'({2'h0, mode.cwl} + {2'h0, mode.al}) - odt_pkg::ODTL_SUB;
  assign cwn4 = 6'(odtl + odt_pkg::CWN_BC4);
  assign cwn8 = 6'(odtl + odt_pkg::CWN_BL8);

  // taps read the history with this rise already in, else one late
  assign odt_hist_next = {odt_hist_reg[odt_pkg::HIST_W-2:0], pin_s.odt};
  assign wr_hist_next = {wr_hist_reg[odt_pkg::HIST_W-2:0], pin_s.wr};
  assign bc4_hist_next = {bc4_hist_reg[odt_pkg::HIST_W-2:0], pin_s.bc4};

  // one sample per link cycle; next index k is k cycles after registering
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      odt_hist_reg <= '0;
      wr_hist_reg <= '0;
      bc4_hist_reg <= '0;
    end else if (ck_rise) begin
      odt_hist_reg <= odt_hist_next;
      wr_hist_reg <= wr_hist_next;
      bc4_hist_reg <= bc4_hist_next;
    end
  end

  assign on_due = odt_hist_next[odtl];
  assign cnw_due = wr_hist_next[odtl];
  assign cwn_due = (wr_hist_next[cwn4] && bc4_hist_next[cwn4]) ||
                   (wr_hist_next[cwn8] && !bc4_hist_next[cwn8]);

  // on at rise, off at following fall
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      term_reg <= 1'b0;
      off_pend_reg <= 1'b0;
    end else if (ignore_pin) begin
      term_reg <= 1'b0;
      off_pend_reg <= 1'b0;
    end else if (ck_rise) begin
      off_pend_reg <= !on_due;
      if (on_due)
        term_reg <= 1'b1;
    end else if (ck_fall && off_pend_reg) begin
      term_reg <= 1'b0;
      off_pend_reg <= 1'b0;
    end
  end

  // strength changes wait for the falling edge as well
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnw_pend_reg <= 1'b0;
      cwn_pend_reg <= 1'b0;
    end else if (ck_rise) begin
      cnw_pend_reg <= cnw_due;
      cwn_pend_reg <= cwn_due;
    end else if (ck_fall) begin
      cnw_pend_reg <= 1'b0;
      cwn_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      rtt_sel_wr_reg <= 1'b0;
    else if (!dyn_en)
      rtt_sel_wr_reg <= 1'b0;
    else if (ck_fall && cnw_pend_reg)
      rtt_sel_wr_reg <= 1'b1;
    else if (ck_fall && cwn_pend_reg)
      rtt_sel_wr_reg <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rtt_on_reg <= 1'b0;
      rtt_value_reg <= odt_pkg::RTT_RST;
    end else begin
      rtt_on_reg <= term_reg && !dq_drive;
      rtt_value_reg <= rtt_sel_wr_reg ? {1'b0, mode.rtt_wr} : mode.rtt_nom;
    end
  end

  AST_DYN_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    !dyn_en |=> !rtt_sel_wr_reg)
    else $error("write strength kept with dynamic termination off");

  AST_NO_SWITCH: assert property (@(posedge clock) disable iff (!rst_n)
    (!dyn_en && ck_fall && cnw_pend_reg) ##1 !dyn_en
    |-> !rtt_sel_wr_reg)
    else $error("write switched strength while dynamic termination off");

  AST_IGNORE: assert property (@(posedge clock) disable iff (!rst_n)
    ignore_pin |=> !term_reg ##1 !rtt_on_reg)
    else $error("termination on while pin must be ignored");

  AST_NO_DRIVE: assert property (@(posedge clock) disable iff (!rst_n)
    dq_drive |=> !rtt_on_reg)
    else $error("termination on while driving data");

  AST_ON_LAT: assert property (@(posedge clock) disable iff (!rst_n)
    (ck_rise && on_due && !ignore_pin) |=> term_reg)
    else $error("termination missed turn-on latency");

  AST_OFF_HALF: assert property (@(posedge clock) disable iff (!rst_n)
    (ck_rise && term_reg && !ignore_pin) |=> term_reg)
    else $error("termination turned off on a rising edge");

  // off at end of off latency
  AST_OFF_LAT: assert property (@(posedge clock) disable iff (!rst_n)
    (ck_fall && off_pend_reg && !ignore_pin && !$past(ck_rise))
    |=> !term_reg)
    else $error("termination missed turn-off latency");

  AST_CNW: assert property (@(posedge clock) disable iff (!rst_n)
    (ck_fall && cnw_pend_reg && dyn_en) |=> rtt_sel_wr_reg)
    else $error("write strength not selected after write latency");

  AST_CWN: assert property (@(posedge clock) disable iff (!rst_n)
    (ck_fall && cwn_pend_reg && !cnw_pend_reg) |=> !rtt_sel_wr_reg)
    else $error("nominal strength not restored after write");

  AST_VALUE: assert property (@(posedge clock) disable iff (!rst_n)
    !rtt_sel_wr_reg |=> rtt_value_reg == $past(mode.rtt_nom))
    else $error("nominal value not taken from mode register 1");

  COV_TERM_ON: cover property (@(posedge clock) disable iff (!rst_n)
    !rtt_on_reg ##1 rtt_on_reg);
  COV_DYN_WRITE: cover property (@(posedge clock) disable iff (!rst_n)
    !rtt_sel_wr_reg ##1 rtt_sel_wr_reg);
  COV_RETURN: cover property (@(posedge clock) disable iff (!rst_n)
    rtt_sel_wr_reg ##1 !rtt_sel_wr_reg);
  COV_READ_GAP: cover property (@(posedge clock) disable iff (!rst_n)
    term_reg && dq_drive);
endmodule // odt_term_ctl

// [sim/odt_ctl_model.sv]
// controller-side model: free link clock and termination pins
`timescale 1ns/1ns
module odt_ctl_model (
  output logic link_ck,
  output odt_pkg::odt_pin_t pins
);
  // memory clock runs free, pins change mid-cycle for margin
  initial begin
    link_ck = 1'h0;
    pins = '0;
    #43;
    forever #40 link_ck = ~link_ck;
  end

  task automatic burst(input logic w, input logic b, input int hi);
    int need;
    need = (w && !b) ? 6 : 4;
    if (hi < need) hi = need;
    @(negedge link_ck);
    pins <= '{odt: 1'h1, wr: w, bc4: b};
    @(negedge link_ck);
    // burst size no longer qualified: show the inverse
    pins.wr <= 1'h0;
    pins.bc4 <= ~b;
    repeat (hi - 1) @(negedge link_ck);
    pins.odt <= 1'h0;
  endtask
endmodule // odt_ctl_model

// [sim/odt_term_ctl_test.sv]
// self-checking bench for termination control
`timescale 1ns/1ns
module odt_term_ctl_test;
  logic clock, rst_n, link_ck, sref, dq_drive, rtt_on_reg, rtt_sel_wr_reg;
  logic [2:0] rtt_value_reg;
  odt_pkg::odt_pin_t pins;
  odt_pkg::odt_mode_t mode;
  int fail_count = 0;
  int checked = 0;
  wire [4:0] st = {rtt_on_reg, rtt_sel_wr_reg, rtt_value_reg};
  typedef struct {
    int cwl, al;
    logic [2:0] nom;
    logic [1:0] wv;
    logic w, b, s, d;
    int hi;
  } odt_row_t;
  // cwl al nom wr write chop sref read hold
  odt_row_t rows [9] = '{
    '{5, 0, 3'h1, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4},
    '{5, 0, 3'h2, 2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 6},
    '{5, 0, 3'h4, 2'h2, 1'h1, 1'h1, 1'h0, 1'h0, 4},
    '{6, 2, 3'h3, 2'h3, 1'h1, 1'h0, 1'h0, 1'h0, 8},
    '{5, 0, 3'h5, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 6},
    '{5, 0, 3'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 5},
    '{5, 0, 3'h0, 2'h2, 1'h1, 1'h1, 1'h0, 1'h0, 4},
    '{5, 0, 3'h1, 2'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4},
    '{5, 0, 3'h6, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4}};

  odt_term_ctl odt_term_ctl_i (.clock(clock), .rst_n(rst_n),
    .link_ck(link_ck), .pins(pins), .mode(mode), .sref(sref),
    .dq_drive(dq_drive), .rtt_on_reg(rtt_on_reg),
    .rtt_sel_wr_reg(rtt_sel_wr_reg), .rtt_value_reg(rtt_value_reg));
  odt_ctl_model odt_ctl_model_i (.link_ck(link_ck), .pins(pins));

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one row: burst at R0, state sampled 20 ns after each later rise
  task automatic run(input odt_row_t r);
    int l, c;
    logic on, sel;
    logic [2:0] v;
    l = r.cwl + r.al - 2;
    c = r.b ? 4 : 6;
    @(posedge clock);
    mode <= '{rtt_nom: r.nom, rtt_wr: r.wv, cwl: r.cwl[3:0], al: r.al[3:0]};
    sref <= r.s;
    dq_drive <= r.d;
    fork
      odt_ctl_model_i.burst(r.w, r.b, r.hi);
      begin
        @(negedge link_ck);
        @(posedge link_ck);
        for (int n = 1; n < l + 10; n++) begin
          @(posedge link_ck);
          #20;
          on = n > l && n <= l + r.hi && !r.s && !r.d
            && (r.nom != 3'h0 || r.wv != 2'h0);
          sel = r.w && r.wv != 2'h0 && n > l && n <= l + c;
          v = sel ? {1'h0, r.wv} : r.nom;
          check(st & 5'h10, {on, 4'h0});
          check(st & 5'h08, {1'h0, sel, 3'h0});
          check(st & 5'h07, {2'h0, v});
        end
      end
    join
  endtask

  initial begin
    rst_n = 1'h0;
    sref = 1'h0;
    dq_drive = 1'h0;
    mode = '0;
    repeat (12) @(posedge clock);
    #1 check(st, 5'h00);
    @(posedge clock) rst_n <= 1'h1;
    foreach (rows[i]) run(rows[i]);
    // reset in mid-burst clears everything at once
    @(posedge clock);
    mode <= '{rtt_nom: 3'h1, rtt_wr: 2'h0, cwl: 4'h5, al: 4'h0};
    dq_drive <= 1'h0;
    fork
      odt_ctl_model_i.burst(1'h0, 1'h0, 8);
      begin
        repeat (7) @(posedge link_ck);
        #1 check(st, 5'h11);
        @(posedge clock) rst_n <= 1'h0;
        @(posedge clock);
        #1 check(st, 5'h00);
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        // value picks up the nominal code at the first free edge
        #1 check(st, 5'h01);
      end
    join
    results();
  end

  // rows need about 10 us; generous margin
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule // odt_term_ctl_test
